// file: common/xhp_pkg.sv
package xhp_pkg;
   // ************************************************************
   // Timing, in the 4 ns clock of this design.
   // ************************************************************
   localparam int CLK_PERIOD_PS = 4000;
   localparam int CS_LOW_MIN_P = 4;
   localparam int CS_HIGH_MIN_P = 4;
   localparam int HOLD_FLOAT_MIN_P = 3;
   localparam int GRANT_DROP_MIN_P = 3;
   localparam int RDY_HOLD_MIN_P = 1;
   localparam int RDY_HOLD_MARGIN_PS = 1500;
   localparam int RDY_HOLD_CYC = RDY_HOLD_MIN_P
      + (RDY_HOLD_MARGIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
   localparam logic [CNT_W-1:0] HOLD_FLOAT_CYC = CNT_W'(HOLD_FLOAT_MIN_P);
   localparam logic [CNT_W-1:0] GRANT_DROP_CYC = CNT_W'(GRANT_DROP_MIN_P);
   localparam logic [CNT_W-1:0] CS_LOW_CYC = CNT_W'(CS_LOW_MIN_P);
   localparam logic [CNT_W-1:0] CS_HIGH_CYC = CNT_W'(CS_HIGH_MIN_P);
   localparam logic [CNT_W-1:0] RDY_HOLD_CNT = CNT_W'(RDY_HOLD_CYC);
   // ************************************************************
   // Widths and reset values.
   // ************************************************************
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
   localparam logic [BE_W-1:0] BE_ZERO = 4'h0;
   localparam logic [BE_W-1:0] BE_ALL = 4'hf;
   localparam logic [2:0] SYNC_IDLE_HIGH = 3'h7;
   localparam logic [2:0] SYNC_IDLE_LOW = 3'h0;
endpackage : xhp_pkg

// file: common/xhp_if.sv
`timescale 1ns/1ps
interface xhp_if;
   import xhp_pkg::*;
   logic host_chip_select_n;
   logic host_control_select;
   logic host_read_write_qual;
   logic [BE_W-1:0] byte_lane_enables;
   logic [DATA_W-1:0] host_data_out;
   logic host_data_oe;
   logic [DATA_W-1:0] dev_data_out;
   logic dev_data_oe;
   logic [DATA_W-1:0] expansion_data_bus;
   logic host_ready_n;
   logic host_ready_oe;
   logic bus_hold_request;
   logic bus_hold_grant;
   logic shared_bus_oe;
   logic [BE_W-1:0] dev_bus_be;
   logic address_strobe_n;
   logic bus_write_read_qual;
   logic burst_last_n;
   always_comb begin
      expansion_data_bus = dev_data_oe ? dev_data_out :
         (host_data_oe ? host_data_out : DATA_ZERO);
   end
   modport dev (
      input host_chip_select_n, host_control_select, host_read_write_qual,
      input byte_lane_enables, expansion_data_bus, bus_hold_request,
      output dev_data_out, dev_data_oe, host_ready_n, host_ready_oe,
      output bus_hold_grant, shared_bus_oe, dev_bus_be, address_strobe_n,
      output bus_write_read_qual, burst_last_n
   );
   modport host (
      output host_chip_select_n, host_control_select, host_read_write_qual,
      output byte_lane_enables, host_data_out, host_data_oe, bus_hold_request,
      input expansion_data_bus, host_ready_n, host_ready_oe, bus_hold_grant,
      input shared_bus_oe
   );
endinterface : xhp_if

// file: rtl/xhp_dev.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Host keeps select low four clocks minimum.
// - Host keeps select high four clocks between.
// - Select qualifiers captured at select falling edge.
// - Byte enables sampled at select rising edge.
// - Write data taken at select rising edge.
// - Data driven only after select falls, reads.
// - Ready asserted only once read data driven.
// - Host holds select one clock after ready.
// - Ready returns high after select rises.
// - Data released within four clocks of rise.
// - Direction polarity of qualifier chosen at boot.
// - Floated group: enables, strobe, qualifier, burst-last.
// - Pending transactions finish before grant.
// - Float no earlier than three clocks after request.
// - Grant within two clocks after floating.
// - Requester holds request one clock after grant.
// - Grant drops three clocks after request falls.
// - Bus driven again within two clocks.
// - Ready is active low toward host.
module xhp_dev (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_write_high_pol,
   input wire logic [xhp_pkg::DATA_W-1:0] i_rd_data,
   input wire logic i_own_busy,
   output logic o_wr_valid,
   output logic [xhp_pkg::DATA_W-1:0] o_wr_data,
   output logic [xhp_pkg::BE_W-1:0] o_wr_be,
   output logic o_wr_ctl,
   output logic o_rd_req,
   output logic o_rd_ctl,
   output logic o_bus_released,
   xhp_if.dev bus
);
   import xhp_pkg::*;

   // ************************************************************
   // State.
   // ************************************************************
   typedef enum logic [1:0] {
      ARB_OWN = 2'b00,
      ARB_WAIT = 2'b01,
      ARB_FLOAT = 2'b10,
      ARB_GRANT = 2'b11
   } xhp_arb_t;

   typedef struct packed {
      logic [2:0] cs_sync;
      logic [2:0] hold_sync;
      logic cs_low;
      logic hold_req;
      logic write_pol;
      logic pol_taken;
      logic acc_write;
      logic acc_ctl;
      logic data_oe;
      logic [DATA_W-1:0] data_out;
      logic rdy_n;
      logic rdy_oe;
      logic rd_req;
      logic wr_valid;
      logic [DATA_W-1:0] wr_data;
      logic [BE_W-1:0] wr_be;
      xhp_arb_t arb;
      logic [CNT_W-1:0] cnt;
      logic bus_oe;
      logic grant;
   } xhp_dev_t;

   xhp_dev_t r;
   xhp_dev_t next_r;
   logic cs_fall;
   logic cs_rise;
   logic qual_write;

   always_comb begin
      next_r = r;
      next_r.rd_req = 1'b0;
      next_r.wr_valid = 1'b0;
      // The first stage is read only by the second stage.
      next_r.cs_sync = {r.cs_sync[1:0], bus.host_chip_select_n};
      next_r.hold_sync = {r.hold_sync[1:0], bus.bus_hold_request};
      // A change counts once the second and third stages agree.
      if (r.cs_sync[1] == r.cs_sync[2]) begin
         next_r.cs_low = ~r.cs_sync[2];
      end
      if (r.hold_sync[1] == r.hold_sync[2]) begin
         next_r.hold_req = r.hold_sync[2];
      end
      cs_fall = next_r.cs_low & ~r.cs_low;
      cs_rise = ~next_r.cs_low & r.cs_low;
      // Polarity strap caught once after reset release.
      if (!r.pol_taken) begin
         next_r.write_pol = i_write_high_pol;
         next_r.pol_taken = 1'b1;
      end
      qual_write = (bus.host_read_write_qual == r.write_pol);
      if (cs_fall) begin
         next_r.acc_write = qual_write;
         next_r.acc_ctl = bus.host_control_select;
         next_r.rdy_oe = 1'b1;
         if (!qual_write) begin
            next_r.rd_req = 1'b1;
         end
      end
      // Read data is driven one clock after the request, ready follows.
      if (r.rd_req) begin
         next_r.data_out = i_rd_data;
         next_r.data_oe = 1'b1;
      end
      if (r.data_oe && r.cs_low && !cs_rise) begin
         next_r.rdy_n = 1'b0;
      end
      if (r.acc_write && r.cs_low && !r.rd_req) begin
         next_r.rdy_n = 1'b0;
      end
      if (cs_rise) begin
         // The host keeps its write data past the rise, so this late sample still finds it.
         next_r.rdy_n = 1'b1;
         next_r.data_oe = 1'b0;
         if (r.acc_write) begin
            next_r.wr_valid = 1'b1;
            next_r.wr_data = bus.expansion_data_bus;
            next_r.wr_be = bus.byte_lane_enables;
         end
      end
      // A new access wins over the idle clear, or the enable would never rise.
      if (!r.cs_low && r.rdy_n && !cs_fall) begin
         next_r.rdy_oe = 1'b0;
      end
      // ************************************************************
      // Hold arbitration.
      // ************************************************************
      case (r.arb)
         ARB_OWN: begin
            if (r.hold_req) begin
               next_r.arb = ARB_WAIT;
               next_r.cnt = HOLD_FLOAT_CYC;
            end
         end
         ARB_WAIT: begin
            if (r.cnt != CNT_ZERO) begin
               next_r.cnt = r.cnt - CNT_ONE;
            end else if (!i_own_busy) begin
               // Floating only with no own transfer pending means none is ever cut short.
               next_r.bus_oe = 1'b0;
               next_r.arb = ARB_FLOAT;
            end
         end
         ARB_FLOAT: begin
            next_r.grant = 1'b1;
            next_r.arb = ARB_GRANT;
            next_r.cnt = GRANT_DROP_CYC;
         end
         ARB_GRANT: begin
            // The wait restarts if the request returns early.
            if (r.hold_req) begin
               next_r.cnt = GRANT_DROP_CYC;
            end else if (r.cnt != CNT_ONE) begin
               next_r.cnt = r.cnt - CNT_ONE;
            end else begin
               next_r.grant = 1'b0;
               next_r.arb = ARB_OWN;
            end
         end
         default: begin
            next_r.arb = ARB_OWN;
         end
      endcase
      if (r.arb == ARB_OWN && !r.grant) begin
         next_r.bus_oe = 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         r <= '0;
         r.cs_sync <= SYNC_IDLE_HIGH;
         r.hold_sync <= SYNC_IDLE_LOW;
         r.rdy_n <= 1'b1;
         r.bus_oe <= 1'b1;
         r.arb <= ARB_OWN;
      end else begin
         r <= next_r;
      end
   end

   assign bus.dev_data_out = r.data_out;
   assign bus.dev_data_oe = r.data_oe;
   assign bus.host_ready_n = r.rdy_n;
   assign bus.host_ready_oe = r.rdy_oe;
   assign bus.bus_hold_grant = r.grant;
   assign bus.shared_bus_oe = r.bus_oe;
   // Idle levels of the shared group; they only matter while this side owns it.
   assign bus.dev_bus_be = BE_ALL;
   assign bus.address_strobe_n = 1'b1;
   assign bus.bus_write_read_qual = ~r.write_pol;
   assign bus.burst_last_n = 1'b1;
   assign o_wr_valid = r.wr_valid;
   assign o_wr_data = r.wr_data;
   assign o_wr_be = r.wr_be;
   assign o_wr_ctl = r.acc_ctl;
   assign o_rd_req = r.rd_req;
   assign o_rd_ctl = r.acc_ctl;
   assign o_bus_released = ~r.bus_oe;
endmodule : xhp_dev

// file: rtl/xhp_host.sv
`timescale 1ns/1ps
module xhp_host (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_write_high_pol,
   input wire logic i_req,
   input wire logic i_req_write,
   input wire logic i_req_ctl,
   input wire logic [xhp_pkg::DATA_W-1:0] i_req_data,
   input wire logic [xhp_pkg::BE_W-1:0] i_req_be,
   input wire logic i_hold_want,
   output logic o_busy,
   output logic o_done,
   output logic [xhp_pkg::DATA_W-1:0] o_rd_data,
   output logic o_hold_owned,
   xhp_if.host bus
);
   import xhp_pkg::*;

   // ************************************************************
   // State.
   // ************************************************************
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_LOW = 2'b01,
      HS_END = 2'b10,
      HS_GAP = 2'b11
   } xhp_hst_t;

   typedef struct packed {
      logic [2:0] rdy_sync;
      logic [2:0] gnt_sync;
      logic rdy;
      logic gnt;
      xhp_hst_t st;
      logic [CNT_W-1:0] cnt;
      logic cs_n;
      logic ctl;
      logic rw;
      logic wr;
      logic [BE_W-1:0] be;
      logic [DATA_W-1:0] dout;
      logic doe;
      logic done;
      logic [DATA_W-1:0] rdata;
      logic hold;
      logic [CNT_W-1:0] hcnt;
   } xhp_host_t;

   xhp_host_t r;
   xhp_host_t next_r;

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.rdy_sync = {r.rdy_sync[1:0], ~bus.host_ready_n & bus.host_ready_oe};
      next_r.gnt_sync = {r.gnt_sync[1:0], bus.bus_hold_grant};
      if (r.rdy_sync[1] == r.rdy_sync[2]) begin
         next_r.rdy = r.rdy_sync[2];
      end
      if (r.gnt_sync[1] == r.gnt_sync[2]) begin
         next_r.gnt = r.gnt_sync[2];
      end
      case (r.st)
         HS_IDLE: begin
            if (i_req) begin
               next_r.cs_n = 1'b0;
               next_r.ctl = i_req_ctl;
               next_r.wr = i_req_write;
               next_r.rw = i_req_write ? i_write_high_pol : ~i_write_high_pol;
               next_r.be = i_req_be;
               next_r.dout = i_req_data;
               next_r.doe = i_req_write;
               next_r.cnt = CS_LOW_CYC;
               next_r.st = HS_LOW;
            end
         end
         HS_LOW: begin
            if (r.cnt != CNT_ZERO) begin
               next_r.cnt = r.cnt - CNT_ONE;
            end
            if (r.rdy && r.cnt == CNT_ZERO) begin
               next_r.rdata = bus.expansion_data_bus;
               next_r.cnt = RDY_HOLD_CNT;
               next_r.st = HS_END;
            end
         end
         HS_END: begin
            if (r.cnt != CNT_ZERO) begin
               next_r.cnt = r.cnt - CNT_ONE;
            end else begin
               next_r.cs_n = 1'b1;
               next_r.cnt = CS_HIGH_CYC;
               next_r.st = HS_GAP;
            end
         end
         HS_GAP: begin
            // Write data stands through the gap, past the late synchronised sample.
            if (r.cnt != CNT_ZERO) begin
               next_r.cnt = r.cnt - CNT_ONE;
            end else if (!r.rdy) begin
               // Ending only once ready is seen high keeps a stale ready out of the next access.
               next_r.doe = 1'b0;
               next_r.done = 1'b1;
               next_r.st = HS_IDLE;
            end
         end
         default: begin
            next_r.st = HS_IDLE;
         end
      endcase
      if (i_hold_want) begin
         next_r.hold = 1'b1;
         next_r.hcnt = CNT_ONE;
      end else if (r.gnt && r.hcnt != CNT_ZERO) begin
         next_r.hcnt = r.hcnt - CNT_ONE;
      end else if (!r.gnt || r.hcnt == CNT_ZERO) begin
         next_r.hold = r.gnt ? 1'b0 : r.hold & i_hold_want;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         r <= '0;
         r.cs_n <= 1'b1;
         r.st <= HS_IDLE;
      end else begin
         r <= next_r;
      end
   end

   assign bus.host_chip_select_n = r.cs_n;
   assign bus.host_control_select = r.ctl;
   assign bus.host_read_write_qual = r.rw;
   assign bus.byte_lane_enables = r.be;
   assign bus.host_data_out = r.dout;
   assign bus.host_data_oe = r.doe;
   assign bus.bus_hold_request = r.hold;
   assign o_busy = (r.st != HS_IDLE);
   assign o_done = r.done;
   assign o_rd_data = r.rdata;
   assign o_hold_owned = r.gnt;
endmodule : xhp_host

// file: tb/xhp_assertions.sv
`timescale 1ns/1ps
// ************************************************************
// Interface timing checks between the two ends.
// ************************************************************
module xhp_assertions (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic host_chip_select_n,
   input wire logic host_data_oe,
   input wire logic dev_data_oe,
   input wire logic host_ready_n,
   input wire logic host_ready_oe,
   input wire logic bus_hold_request,
   input wire logic bus_hold_grant,
   input wire logic shared_bus_oe
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   drive_after_select_a: assert property (
      $rose(dev_data_oe) |-> !host_chip_select_n && $past(!host_chip_select_n, 2))
      else $error("data bus driven without a settled select");
   ready_with_data_a: assert property (
      $fell(host_ready_n) && !host_data_oe |-> dev_data_oe)
      else $error("read ready before read data");
   ready_returns_high_a: assert property (
      $rose(host_chip_select_n) |-> ##[0:6] host_ready_n)
      else $error("ready not returned high after select rise");
   data_released_a: assert property (
      $rose(host_chip_select_n) && dev_data_oe |-> ##[1:4] !dev_data_oe)
      else $error("data bus not released after select rise");
   ready_driven_low_a: assert property (
      !host_ready_n |-> host_ready_oe)
      else $error("ready low while not driven");
   float_not_early_a: assert property (
      $rose(bus_hold_request) |-> shared_bus_oe [*3])
      else $error("bus floated too soon after hold request");
   grant_after_float_a: assert property (
      $fell(shared_bus_oe) |-> ##[1:2] bus_hold_grant)
      else $error("grant late after floating");
   grant_needs_float_a: assert property (
      bus_hold_grant |-> !shared_bus_oe)
      else $error("grant while bus still driven");
   grant_kept_a: assert property (
      $fell(bus_hold_request) && bus_hold_grant |-> bus_hold_grant [*3])
      else $error("grant dropped too soon");
   bus_reclaimed_a: assert property (
      $fell(bus_hold_grant) |-> ##[1:2] shared_bus_oe)
      else $error("bus not driven again after grant drop");
endmodule : xhp_assertions

// file: tb/shared_bus_group_async_host_port_and_hold_arbiter_bench.sv
`timescale 1ns/1ps
// ************************************************************
// Both ends face each other; the bench drives their user sides.
// ************************************************************
module shared_bus_group_async_host_port_and_hold_arbiter_bench;
   import xhp_pkg::*;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic pol = 1'b1;
   logic own_busy = 1'b0;
   logic req = 1'b0;
   logic req_write = 1'b0;
   logic req_ctl = 1'b0;
   logic hold_want = 1'b0;
   logic [DATA_W-1:0] rd_data = DATA_ZERO;
   logic [DATA_W-1:0] req_data = DATA_ZERO;
   logic [BE_W-1:0] req_be = BE_ZERO;
   logic [BE_W-1:0] bes [4] = '{4'h1, 4'h6, 4'h8, 4'hf};
   logic wr_valid, wr_ctl, rd_req, rd_ctl, released, busy, done, owned;
   logic [DATA_W-1:0] wr_data, host_rd, seen_wd, bus_wd;
   logic [BE_W-1:0] wr_be, seen_be, bus_be;
   logic seen_wc, qual_fall;
   int n_rd = 0;
   int n_wr = 0;
   int n_errors = 0;
   int checks_done = 0;
   xhp_if xb ();
   always #2 i_clk = ~i_clk;
   xhp_dev i_xhp_dev (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_write_high_pol(pol),
      .i_rd_data(rd_data), .i_own_busy(own_busy), .o_wr_valid(wr_valid),
      .o_wr_data(wr_data), .o_wr_be(wr_be), .o_wr_ctl(wr_ctl), .o_rd_req(rd_req),
      .o_rd_ctl(rd_ctl), .o_bus_released(released), .bus(xb.dev)
   );
   xhp_host i_xhp_host (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_write_high_pol(pol), .i_req(req),
      .i_req_write(req_write), .i_req_ctl(req_ctl), .i_req_data(req_data),
      .i_req_be(req_be), .i_hold_want(hold_want), .o_busy(busy), .o_done(done),
      .o_rd_data(host_rd), .o_hold_owned(owned), .bus(xb.host)
   );
   xhp_assertions i_xhp_assertions (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .host_chip_select_n(xb.host_chip_select_n), .host_data_oe(xb.host_data_oe),
      .dev_data_oe(xb.dev_data_oe), .host_ready_n(xb.host_ready_n),
      .host_ready_oe(xb.host_ready_oe), .bus_hold_request(xb.bus_hold_request),
      .bus_hold_grant(xb.bus_hold_grant), .shared_bus_oe(xb.shared_bus_oe)
   );
   // Pulses are caught mid-cycle so that the launching edge has settled.
   always @(negedge i_clk) begin
      if (wr_valid === 1'b1) begin
         n_wr++;
         seen_wd = wr_data;
         seen_be = wr_be;
         seen_wc = wr_ctl;
      end
      if (rd_req === 1'b1) begin
         n_rd++;
      end
   end
   always @(negedge xb.host_chip_select_n) #1 qual_fall = xb.host_read_write_qual;
   always @(posedge xb.host_chip_select_n) begin
      bus_be = xb.byte_lane_enables;
      bus_wd = xb.expansion_data_bus;
   end
   task automatic results();
      $display("counts: %0d checks, %0d mismatches", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results
   task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // A wait that runs out is counted and ends the run, so a hang never stalls it.
   task automatic wait_lvl(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 300) begin
         @(negedge i_clk);
         n++;
      end
      check("wait level", s, v);
      if (s !== v) begin
         results();
      end
   endtask : wait_lvl
   task automatic do_reset(input logic p);
      pol = p;
      i_sys_rst = 1'b1;
      repeat (10) @(negedge i_clk);
      i_sys_rst = 1'b0;
      repeat (2) @(negedge i_clk);
   endtask : do_reset
   task automatic access(input logic w, c, input logic [DATA_W-1:0] d,
      input logic [BE_W-1:0] be);
      int r0;
      int w0;
      r0 = n_rd;
      w0 = n_wr;
      rd_data = d;
      req_write = w;
      req_ctl = c;
      req_data = d;
      req_be = be;
      req = 1'b1;
      @(negedge i_clk);
      req = 1'b0;
      wait_lvl(done, 1'b1);
      if (w === 1'b0) begin
         check("read data", host_rd, d);
         check("read control", rd_ctl, c);
      end
      wait_lvl(xb.host_ready_oe, 1'b0);
      check("qualifier", qual_fall, w == pol);
      check("data released", xb.dev_data_oe, 1'b0);
      check("ready idle", xb.host_ready_n, 1'b1);
      check("read requests", n_rd - r0, w ? 0 : 1);
      check("write strobes", n_wr - w0, w ? 1 : 0);
      if (w === 1'b1) begin
         check("write data", seen_wd, d);
         check("write enables", seen_be, be);
         check("write control", seen_wc, c);
         check("wire enables", bus_be, be);
         check("wire data", bus_wd, d);
      end
      wait_lvl(busy, 1'b0);
   endtask : access
   initial begin
      do_reset(1'b1);
      check("idle ready", xb.host_ready_n, 1'b1);
      check("idle grant", xb.bus_hold_grant, 1'b0);
      check("idle bus owned", xb.shared_bus_oe, 1'b1);
      check("idle strobe", xb.address_strobe_n, 1'b1);
      check("idle burst last", xb.burst_last_n, 1'b1);
      check("idle enables", xb.dev_bus_be, BE_ALL);
      for (int p = 1; p >= 0; p--) begin
         do_reset(p[0]);
         check("idle direction", xb.bus_write_read_qual, p == 0);
         for (int k = 0; k < 4; k++) begin
            access(1'b1, k[0], 32'h5a00_0000 + k + 16 * p, bes[k]);
            access(1'b0, k[1], 32'hc300_0000 + k + 16 * p, bes[k]);
         end
         $display("test polarity %0d done", p);
      end
      own_busy = 1'b1;
      hold_want = 1'b1;
      repeat (20) @(negedge i_clk);
      check("grant while busy", xb.bus_hold_grant, 1'b0);
      check("bus kept while busy", xb.shared_bus_oe, 1'b1);
      own_busy = 1'b0;
      wait_lvl(owned, 1'b1);
      check("grant", xb.bus_hold_grant, 1'b1);
      check("bus floated", xb.shared_bus_oe, 1'b0);
      check("released flag", released, 1'b1);
      hold_want = 1'b0;
      wait_lvl(xb.bus_hold_grant, 1'b0);
      repeat (2) @(negedge i_clk);
      check("bus reclaimed", xb.shared_bus_oe, 1'b1);
      $display("test hold done");
      access(1'b1, 1'b0, 32'h0f0f_1234, 4'hf);
      $display("test after hold done");
      results();
   end
endmodule : shared_bus_group_async_host_port_and_hold_arbiter_bench
